//--- srsc_regs.vh
// Constants of the serial regenerator and speed converter.
`ifndef SRSC_REGS_VH
`define SRSC_REGS_VH
// ******************************************************************
// Register map, byte addresses
// ******************************************************************
`define SRSC_CTRL_OFS      4'h0
`define SRSC_SPEED_OFS     4'h4
`define SRSC_FORMAT_OFS    4'h8
`define SRSC_STATUS_OFS    4'hC
// ******************************************************************
// Control fields
// ******************************************************************
`define SRSC_CTRL_REGENERATION_CONTROL    0
`define SRSC_CTRL_CONVERT  1
`define SRSC_CTRL_SEND     2
`define SRSC_CTRL_INVERT   3
`define SRSC_CTRL_RESET    32'h0000_0003
// ******************************************************************
// Speed fields: signal speed in [7:0], loop speed in [15:8]
// ******************************************************************
`define SRSC_SPEED_RESET   32'h0000_3232
// ******************************************************************
// Format fields: [3:2] data bits minus five, 4 long stop, 5 auto stop
// ******************************************************************
`define SRSC_FMT_LEN_LO    2
`define SRSC_FMT_LONGSTOP  4
`define SRSC_FMT_AUTOSTOP  5
`define SRSC_FORMAT_RESET  32'h0000_0000
// ******************************************************************
// Timing
// ******************************************************************
`define SRSC_REF_HZ        60000
`define SRSC_MCLK_HZ       40000000
`define SRSC_OVERSAMPLE    16
`endif

//--- srsc_bcd_divider.v
// Decimal-programmable divider producing one-cycle enable pulses.
`timescale 1ns/1ps
module srsc_bcd_divider (
  input  wire       mclk,
  input  wire       rstSync_n,
  input  wire       refTick,
  input  wire [7:0] bcdSetting,
  output reg        clkPulse,
  output wire       settingInvalid
);
  // Upper nibble is tens, lower nibble is units.
  function [6:0] bcdValue;
    input [7:0] b;
    begin
      bcdValue = {3'b000, b[7:4]} * 7'd10 + {3'b000, b[3:0]};
    end
  endfunction

  reg  [6:0] count_reg;
  wire [6:0] divisor = bcdValue(bcdSetting);

  // A zero divisor or a digit above nine stops the clock.
  assign settingInvalid = (divisor == 7'd0) || (bcdSetting[7:4] > 4'd9) ||
                          (bcdSetting[3:0] > 4'd9);                // [R17]

  always @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      count_reg <= 7'd0;
      clkPulse  <= 1'b0;
    end else begin
      clkPulse <= 1'b0;
      if (settingInvalid) begin
        count_reg <= 7'd0;
      end else if (refTick) begin
        if (count_reg + 7'd1 >= divisor) begin                     // [R17]
          count_reg <= 7'd0;
          clkPulse  <= 1'b1;                                       // [R13]
        end else begin
          count_reg <= count_reg + 7'd1;
        end
      end
    end
  end
endmodule // srsc_bcd_divider

//--- srsc_regenerator.v
// Half-duplex serial regenerator and speed converter with AXI4-Lite slave.
// Functional notes
// [R1] Output bits are timed by a crystal-derived clock, not by input edges.
// [R2] Serial input may be inverted to convert mark-negative into mark-high.
// [R3] Half duplex; direction from send control or external lock input.
// [R4] One format serves receiver and transmitter, each with its own clock.
// [R5] Same clock on both halves gives regeneration at the input rate.
// [R6] Speed conversion clocks the halves at independent rates.
// [R7] Software should set output clock as fast as input; one char buffer.
// [R8] Two identical programmable dividers run from one reference tick.
// [R9] Without conversion both halves use the first divider.
// [R10] With conversion the second divider sets the shift-out rate.
// [R11] Output divider settings span 37.5 to 3750 baud; BCD settings 01 to 99 here reach 3750 down to about 37.9 baud.
// [R12] Second setting: bits 7..4 upper BCD digit, bits 3..0 lower.
// [R13] Each divider yields sixteen times baud; divisor is 60000 over that.
// [R14] Receive: divider one clocks input; send: clocks swap.
// [R15] Stop element of one or one and a half units is appended.
// [R16] Auto stop with one-unit stop: one unit receive, 1.5 in send.
// [R17] Divider reloads at programmed BCD count; zero is invalid.
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "srsc_regs.vh"
module srsc_regenerator #(
  parameter integer REF_DIV = `SRSC_MCLK_HZ / `SRSC_REF_HZ) (
  input  wire        mclk,
  input  wire        arst_n,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [3:0]  s_axi_araddr,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  input  wire        lockIn,
  input  wire        serialIn,
  output reg         serialOut
);
  // ****************************************************************
  // Reset and input synchronisers
  // ****************************************************************
  reg [1:0] rstPipe_reg;
  wire      rstSync_n = rstPipe_reg[1];
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rstPipe_reg <= 2'b00;
    end else begin
      rstPipe_reg <= {rstPipe_reg[0], 1'b1};
    end
  end

  reg [1:0] rxPipe_reg;
  reg [1:0] lockPipe_reg;
  always @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      rxPipe_reg   <= 2'b11;
      lockPipe_reg <= 2'b00;
    end else begin
      rxPipe_reg   <= {rxPipe_reg[0], serialIn};
      lockPipe_reg <= {lockPipe_reg[0], lockIn};
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  reg  [31:0] ctrl_reg;
  reg  [31:0] speed_reg;
  reg  [31:0] format_reg;
  reg         overrun_reg;
  reg         awHeld_reg;
  reg         wHeld_reg;
  reg  [3:0]  awAddr_reg;
  reg  [31:0] wData_reg;
  reg  [3:0]  wStrb_reg;

  assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire        awGo   = awHeld_reg || s_axi_awvalid;
  wire        wGo    = wHeld_reg || s_axi_wvalid;
  wire [3:0]  wrAddr = awHeld_reg ? awAddr_reg : s_axi_awaddr;
  wire [31:0] wrData = wHeld_reg ? wData_reg : s_axi_wdata;
  wire [3:0]  wrStrb = wHeld_reg ? wStrb_reg : s_axi_wstrb;
  wire        doWrite = awGo && wGo && !s_axi_bvalid;
  wire        wrHit  = (wrAddr == `SRSC_CTRL_OFS) ||
                       (wrAddr == `SRSC_SPEED_OFS) ||
                       (wrAddr == `SRSC_FORMAT_OFS) ||
                       (wrAddr == `SRSC_STATUS_OFS);
  wire        clearOverrun;
  wire        setOverrun;

  function [31:0] applyStrobe;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0]  strb;
    integer i;
    begin
      applyStrobe = oldVal;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          applyStrobe[i*8 +: 8] = newVal[i*8 +: 8];
        end
      end
    end
  endfunction

  assign clearOverrun = doWrite && (wrAddr == `SRSC_STATUS_OFS) &&
                        wrStrb[0] && wrData[0];

  always @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      ctrl_reg     <= `SRSC_CTRL_RESET;
      speed_reg    <= `SRSC_SPEED_RESET;
      format_reg   <= `SRSC_FORMAT_RESET;
      awHeld_reg   <= 1'b0;
      wHeld_reg    <= 1'b0;
      awAddr_reg   <= 4'h0;
      wData_reg    <= 32'h0000_0000;
      wStrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (doWrite) begin
        awHeld_reg   <= 1'b0;
        wHeld_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? 2'b00 : 2'b10;
        case (wrAddr)
          `SRSC_CTRL_OFS:
            ctrl_reg <= applyStrobe(ctrl_reg, wrData, wrStrb) &
                        32'h0000_000F;
          `SRSC_SPEED_OFS:
            speed_reg <= applyStrobe(speed_reg, wrData, wrStrb) &
                         32'h0000_FFFF;
          `SRSC_FORMAT_OFS:
            format_reg <= applyStrobe(format_reg, wrData, wrStrb) &
                          32'h0000_003C;
          default: begin
          end
        endcase
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          awHeld_reg <= 1'b1;
          awAddr_reg <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          wHeld_reg <= 1'b1;
          wData_reg <= s_axi_wdata;
          wStrb_reg <= s_axi_wstrb;
        end
      end
    end
  end

  // ****************************************************************
  // Clock generation and steering
  // ****************************************************************
  reg  [9:0] refCount_reg;
  reg        refTick_reg;
  wire       clk1Pulse;
  wire       clk2Pulse;
  wire       clk1Bad;
  wire       clk2Bad;

  // Reference tick is the 60 kHz crystal, approximated from mclk.
  always @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      refCount_reg <= 10'd0;
      refTick_reg  <= 1'b0;
    end else begin
      refTick_reg <= 1'b0;
      if (refCount_reg == REF_DIV[9:0] - 10'd1) begin
        refCount_reg <= 10'd0;
        refTick_reg  <= 1'b1;
      end else begin
        refCount_reg <= refCount_reg + 10'd1;
      end
    end
  end

  srsc_bcd_divider u_signalDiv (                                   // [R8]
    .mclk           (mclk),
    .rstSync_n      (rstSync_n),
    .refTick        (refTick_reg),
    .bcdSetting     (speed_reg[7:0]),
    .clkPulse       (clk1Pulse),
    .settingInvalid (clk1Bad)
  );
  srsc_bcd_divider u_loopDiv (                       // [R10] [R11] [R12]
    .mclk           (mclk),
    .rstSync_n      (rstSync_n),
    .refTick        (refTick_reg),
    .bcdSetting     (speed_reg[15:8]),
    .clkPulse       (clk2Pulse),
    .settingInvalid (clk2Bad)
  );

  wire regenOn   = ctrl_reg[`SRSC_CTRL_REGENERATION_CONTROL];
  wire convertOn = ctrl_reg[`SRSC_CTRL_CONVERT];
  wire sendMode  = ctrl_reg[`SRSC_CTRL_SEND] || lockPipe_reg[1];   // [R3]
  // Without conversion the loop divider is unused on both halves.
  wire altPulse  = convertOn ? clk2Pulse : clk1Pulse;         // [R5] [R9]
  wire rxTick    = sendMode ? altPulse : clk1Pulse;                // [R14]
  wire txTick    = sendMode ? clk1Pulse : altPulse;                // [R6]

  // ****************************************************************
  // Receiver half
  // ****************************************************************
  localparam RX_IDLE = 2'd0;
  localparam RX_START = 2'd1;
  localparam RX_DATA = 2'd2;
  localparam RX_STOP = 2'd3;
  wire       rxLine = rxPipe_reg[1] ^ ctrl_reg[`SRSC_CTRL_INVERT]; // [R2]
  wire [3:0] dataBits = {2'b00, format_reg[3:2]} + 4'd5;           // [R4]
  reg  [1:0] rxState_reg;
  reg  [3:0] rxPhase_reg;
  reg  [3:0] rxBit_reg;
  reg  [7:0] rxShift_reg;
  reg  [7:0] holdData_reg;
  reg        holdFull_reg;
  wire       txTake;

  always @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      rxState_reg  <= RX_IDLE;
      rxPhase_reg  <= 4'd0;
      rxBit_reg    <= 4'd0;
      rxShift_reg  <= 8'h00;
      holdData_reg <= 8'h00;
      holdFull_reg <= 1'b0;
    end else begin
      if (txTake) begin
        holdFull_reg <= 1'b0;
      end
      if (rxTick) begin
        rxPhase_reg <= rxPhase_reg + 4'd1;
        case (rxState_reg)
          RX_IDLE: begin
            rxPhase_reg <= 4'd0;
            if (!rxLine) begin
              rxState_reg <= RX_START;
            end
          end
          RX_START: begin
            if (rxPhase_reg == 4'd7) begin
              rxPhase_reg <= 4'd0;
              rxBit_reg   <= 4'd0;
              rxState_reg <= rxLine ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rxPhase_reg == 4'd15) begin
              rxShift_reg <= {rxLine, rxShift_reg[7:1]};
              rxBit_reg   <= rxBit_reg + 4'd1;
              if (rxBit_reg == dataBits - 4'd1) begin
                rxState_reg <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            // A missing stop is not a reason to drop the character.
            if (rxPhase_reg == 4'd15) begin
              rxState_reg  <= RX_IDLE;
              holdData_reg <= rxShift_reg >> (4'd8 - dataBits);
              holdFull_reg <= 1'b1;
            end
          end
          default: rxState_reg <= RX_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // Transmitter half
  // ****************************************************************
  reg  [3:0] txPhase_reg;
  reg  [4:0] txHalfBits_reg;
  reg  [9:0] txShift_reg;
  reg        txBusy_reg;
  wire       autoStop  = format_reg[`SRSC_FMT_AUTOSTOP];
  wire       longStop  = format_reg[`SRSC_FMT_LONGSTOP] ||
                         (autoStop && sendMode);                   // [R16]
  assign txTake = !txBusy_reg && holdFull_reg && txTick;
  // Overrun: a new character lands while the old is still held.
  assign setOverrun = rxTick && (rxState_reg == RX_STOP) &&
                      (rxPhase_reg == 4'd15) && holdFull_reg && !txTake;

  always @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      txPhase_reg    <= 4'd0;
      txHalfBits_reg <= 5'd0;
      txShift_reg    <= 10'h3FF;
      txBusy_reg     <= 1'b0;
      serialOut      <= 1'b1;
      overrun_reg    <= 1'b0;
    end else begin
      if (setOverrun) begin
        overrun_reg <= 1'b1;
      end else if (clearOverrun) begin
        overrun_reg <= 1'b0;
      end
      if (!regenOn) begin
        serialOut <= rxLine;
      end else if (txBusy_reg) begin
        serialOut <= txShift_reg[0];
      end else begin
        serialOut <= 1'b1;
      end
      if (txTake) begin
        txBusy_reg     <= 1'b1;
        txPhase_reg    <= 4'd0;
        // Frame length in half units: start, data, then 2 or 3 stop.
        txHalfBits_reg <= {dataBits, 1'b0} + (longStop ? 5'd5 : 5'd4); // [R15]
        txShift_reg    <= {1'b1, holdData_reg | (8'hFF << dataBits), 1'b0};
      end else if (txBusy_reg && txTick) begin                     // [R1]
        txPhase_reg <= txPhase_reg + 4'd1;
        if (txPhase_reg[2:0] == 3'd7) begin
          txHalfBits_reg <= txHalfBits_reg - 5'd1;
          if (txPhase_reg[3]) begin
            txShift_reg <= {1'b1, txShift_reg[9:1]};
          end
          if (txHalfBits_reg == 5'd1) begin
            txBusy_reg <= 1'b0;
          end
        end
      end
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  always @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr)
          `SRSC_CTRL_OFS:   s_axi_rdata <= ctrl_reg;
          `SRSC_SPEED_OFS:  s_axi_rdata <= speed_reg;
          `SRSC_FORMAT_OFS: s_axi_rdata <= format_reg;
          `SRSC_STATUS_OFS:
            s_axi_rdata <= {26'd0, clk2Bad, clk1Bad, sendMode,
                            txBusy_reg, holdFull_reg, overrun_reg};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
    end
  end
endmodule // srsc_regenerator

//--- srsc_regenerator_asserts.sv
// Concurrent checks on the register bus ports of the regenerator.
`timescale 1ns/1ps
module srsc_regenerator_asserts (
  input wire        mclk,
  input wire        arst_n,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [3:0]  s_axi_awaddr,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [3:0]  s_axi_araddr,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        lockIn,
  input wire        serialIn,
  input wire        serialOut
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // ****
  // Handshake steps
  // ****
  sequence s_wrPair;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rdTake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_bWait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  sequence s_rWait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  property p_bAfterPair;
    s_wrPair |=> s_axi_bvalid;
  endproperty
  a_bAfterPair: assert property (p_bAfterPair) else $error("bvalid late");
  property p_bHold;
    s_bWait |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bHold: assert property (p_bHold) else $error("bvalid not held");
  property p_bDrop;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_bDrop: assert property (p_bDrop) else $error("bvalid stuck");
  property p_rAfterAr;
    s_rdTake |=> s_axi_rvalid;
  endproperty
  a_rAfterAr: assert property (p_rAfterAr) else $error("rvalid late");
  property p_rHold;
    s_rWait |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_rHold: assert property (p_rHold) else $error("read data moved");
  property p_rDrop;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rDrop: assert property (p_rDrop) else $error("rvalid stuck");
  property p_arBlocked;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_arBlocked: assert property (p_arBlocked) else $error("arready in read");
  property p_awBlocked;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_awBlocked: assert property (p_awBlocked) else $error("awready in resp");
endmodule // srsc_regenerator_asserts

bind srsc_regenerator srsc_regenerator_asserts i_srsc_regenerator_asserts (.*);

//--- srsc_line_partner.sv
// Line-side model: keys characters in and decodes the regenerated output.
`timescale 1ns/1ps
module srsc_line_partner #(
  parameter int UNIT_CYC = 10656
) (
  input  wire        mclk,
  input  wire        monEn,
  input  wire        lineRx,
  output logic       lineTx,
  output logic       charValid,
  output logic [6:0] charData
);
  longint     cyc;
  longint     tFall;
  logic       aligned;
  logic       armed;
  logic [6:0] d;
  initial begin
    cyc = 0;
    lineTx = 1'b1;
    charValid = 1'b0;
    charData = 7'h00;
    aligned = 1'b0;
    armed = 1'b0;
  end
  task automatic setLine(input logic v);
    @(posedge mclk);
    lineTx <= v;
  endtask
  // Start, five data elements LSB first, one stop; 16 ticks each.
  task automatic sendChar(input logic [4:0] c);
    for (int i = 0; i < 7; i++) begin
      setLine(i == 0 ? 1'b0 : (i == 6 ? 1'b1 : c[i-1]));
      repeat (UNIT_CYC - 1) @(posedge mclk);
    end
  endtask
  // Edges are timed in whole clock cycles, so no rounding of time enters.
  always @(posedge mclk) begin
    cyc++;
  end
  // A re-timed output only moves on whole element boundaries.
  always @(posedge lineRx) begin
    if (armed) begin
      aligned = ((cyc - tFall) % UNIT_CYC) == 0;
      armed = 1'b0;
    end
  end
  initial forever begin
    @(negedge lineRx);
    if (monEn) begin
      tFall = cyc;
      armed = 1'b1;
      repeat (UNIT_CYC / 2) @(posedge mclk);
      for (int i = 0; i < 7; i++) begin
        d[i] = lineRx;
        repeat (UNIT_CYC) @(posedge mclk);
      end
      charData <= {d[6] && !d[0], aligned, d[5:1]};
      charValid <= 1'b1;
      @(posedge mclk);
      charValid <= 1'b0;
    end
  end
endmodule // srsc_line_partner

//--- srsc_regenerator_bench.sv
// Self-checking bench for the regenerator and speed converter.
`timescale 1ns/1ps
`include "srsc_regs.vh"
module srsc_regenerator_bench;
  // A fast reference tick keeps one regenerated character short to run.
  localparam int REF_DIV  = 40;
  localparam int UNIT_CYC = 16 * REF_DIV;
  logic        mclk, arst_n, lockIn, monEn;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire         s_axi_rvalid, serialIn, serialOut, charValid;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [6:0]   charData;
  int          errCount, testsRun;
  logic [33:0] expQ[$];
  srsc_regenerator #(.REF_DIV(REF_DIV)) i_srsc_regenerator (.*);
  srsc_line_partner #(.UNIT_CYC(UNIT_CYC)) i_srsc_line_partner (
    .mclk(mclk), .monEn(monEn), .lineRx(serialOut), .lineTx(serialIn),
    .charValid(charValid), .charData(charData));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // ****
  // Result watcher: each result takes the oldest expectation.
  // ****
  always @(posedge mclk) begin
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
    if (charValid) chk({27'h0, charData}, expQ.pop_front());
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk({32'h0, s_axi_bresp}, 34'h0);
  endtask
  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    expQ.push_back(e);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic bad(input logic [7:0] b);
    return b == 8'h00;
  endfunction
  task automatic endTest(input string s);
    $display("test %s done", s);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One character in and out takes about fifteen elements; the rest is short.
  initial begin
    repeat (20 * UNIT_CYC) @(posedge mclk);
    errCount++;
    finish_test;
  end
  initial begin
    logic [7:0] sp, lp;
    logic [4:0] c;
    logic [1:0] pv;
    {arst_n, lockIn, monEn, s_axi_awvalid, s_axi_wvalid} = 5'h00;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 12'h000;
    s_axi_wdata = 32'h0000_0000;
    errCount = 0;
    testsRun = 0;
    void'($urandom(10221));
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(`SRSC_CTRL_OFS, {2'b00, `SRSC_CTRL_RESET});
    rd(`SRSC_SPEED_OFS, {2'b00, `SRSC_SPEED_RESET});
    rd(`SRSC_FORMAT_OFS, {2'b00, `SRSC_FORMAT_RESET});
    rd(`SRSC_STATUS_OFS, 34'h0);
    endTest("reset");
    // Short line pulses here stay far below half an element at 32.
    for (int i = 0; i < 4; i++) begin
      pv = i[1:0];
      wr(`SRSC_CTRL_OFS, {28'h0, pv[1], 3'h0});
      i_srsc_line_partner.setLine(pv[0]);
      repeat (8) @(posedge mclk);
      chk({33'h0, serialOut}, {33'h0, pv[0] ^ pv[1]});
    end
    endTest("invert");
    for (int i = 0; i < 4; i++) begin
      sp = i == 0 ? 8'h00 : {4'($urandom_range(9)), 4'($urandom_range(9))};
      lp = i == 1 ? 8'h00 : {4'($urandom_range(9)), 4'($urandom_range(9))};
      wr(`SRSC_SPEED_OFS, {16'h0, lp, sp});
      rd(`SRSC_SPEED_OFS, {18'h0, lp, sp});
      rd(`SRSC_STATUS_OFS, {26'h0, bad(lp), bad(sp), 4'h0});
    end
    endTest("speed");
    wr(`SRSC_SPEED_OFS, 32'h0000_0101);
    wr(`SRSC_CTRL_OFS, 32'h0000_0007);
    rd(`SRSC_STATUS_OFS, 34'h8);
    wr(`SRSC_CTRL_OFS, 32'h0000_0003);
    lockIn <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(`SRSC_STATUS_OFS, 34'h8);
    lockIn <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(`SRSC_STATUS_OFS, 34'h0);
    endTest("direction");
    wr(`SRSC_FORMAT_OFS, 32'h0000_0000);
    repeat (100) @(posedge mclk);
    monEn <= 1'b1;
    c = 5'($urandom);
    expQ.push_back({27'h0, 2'b11, c});
    i_srsc_line_partner.sendChar(c);
    while (!charValid) @(posedge mclk);
    @(posedge mclk);
    endTest("regeneration_control");
    finish_test;
  end
endmodule // srsc_regenerator_bench
